/* core/vcs_regs.sv */
// two-wire serial register slice of the capture device: sync and output setup
// assumes scl/sda already synchronous to core_clk; sda is open drain
//
// Summary of operation
// RQ1 - host sets power/clamp register bit zero (no such register in this slice)
// RQ2 - separator counts 5 MHz ticks to threshold
// RQ3 - host picks threshold above widest pulse
// RQ4 - hold starts lead lines before frame sync
// RQ5 - hold lasts trail lines after frame sync
// RQ6 - status bits 7:5 line sync info
// RQ7 - status bits 4:2 frame sync info
// RQ8 - status bits 1:0 green sync, hold polarity
// RQ9 - bit 7 single or dual channel
// RQ10 - bit 6 interleaved or parallel output
// RQ11 - bit 5 picks port of first byte
// RQ12 - bit 4 selects 4:4:4 or 4:2:2
// RQ13 - bit 3 drives input multiplexer
// RQ14 - bits 2:1 select analog bandwidth
// RQ15 - bit 0 bypasses pll, external clock
// RQ16 - host writes 11111110 to first factory register
// RQ17 - host leaves second factory register alone
// RQ18 - offset zero returns silicon revision
// RQ19 - twelve-bit divide value, ratio value plus one
// RQ20 - divide ratios two through 4096 supported
// RQ21 - divide value powers up at 1693
// RQ22 - ratio transfers only on lower register write
// RQ23 - writes to read-only registers ignored
// RQ24 - status captured stable for host reads
`timescale 1ns/1ns
`default_nettype none
module vcs_regs #(
  parameter logic [6:0]  DEV_ADDR      = 7'h4C,
  parameter logic [7:0]  REVISION      = 8'h5A,
  parameter int unsigned DETECT_CYCLES = vcs_pkg::DETECT_CYCLES
) (
  input  wire logic  core_clk,
  input  wire logic  rst_n,
  input  wire logic  scl_i,
  input  wire logic  sda_i,
  output logic       sda_o,
  output logic       sda_oe,
  input  wire logic  hsync_pin,
  input  wire logic  sog_pin,
  input  wire logic  vsync_pin,
  input  wire logic  coast_pin,
  output logic       dual_channel,
  output logic       parallel_mode,
  output logic       port_b_first,
  output logic       fmt_422,
  output logic       input_mux_sel,
  output logic [1:0] bandwidth_sel,
  output logic       pll_bypass,
  output logic [11:0] pll_divide_value,
  output logic [12:0] pll_divide_ratio,
  output logic       pll_load,
  output logic       pll_hold
);
  // revision value is arbitrary
  vcs_pkg::vcs_ser_state_e st_q;
  logic scl_q, scl_qq, sda_q, sda_qq;
  logic scl_rise, scl_fall, start_det, stop_det;
  logic [3:0] bit_q;
  logic [7:0] rx_q, tx_q, ptr_q;
  logic rw_q, nack_q, oe_q, zero_q, wr_stb_q;
  logic [7:0] pll_up_q, pll_lo_q, sep_limit_q, lead_q, trail_q;
  logic [7:0] fmt_q, fact_a_q, fact_b_q;
  logic [11:0] pll_val_q;
  logic [12:0] ratio_q;
  logic load_q;
  logic [7:0] rd_byte;
  vcs_sync_if sif ();
  localparam logic [11:0] RST_VALUE = {vcs_pkg::RST_PLL_UPPER, vcs_pkg::RST_PLL_LOWER[7:4]};
  localparam logic [12:0] RST_RATIO = {1'b0, RST_VALUE} + 13'h0001;

  // ----------------------------------------
  // functions
  // ----------------------------------------
  function automatic logic [12:0] div_ratio(input logic [11:0] val);
    logic [11:0] v;
    v = (val < vcs_pkg::PLL_VALUE_MIN) ? vcs_pkg::PLL_VALUE_MIN : val;
    return {1'b0, v} + 13'h0001;
  endfunction

  function automatic logic [7:0] rd_mux(input logic [7:0] a, input logic [7:0] stat);
    case (a)
      vcs_pkg::ADDR_REVISION:   rd_mux = REVISION;
      vcs_pkg::ADDR_PLL_UPPER:  rd_mux = pll_up_q;
      vcs_pkg::ADDR_PLL_LOWER:  rd_mux = pll_lo_q;
      vcs_pkg::ADDR_SEP_LIMIT:  rd_mux = sep_limit_q;
      vcs_pkg::ADDR_HOLD_LEAD:  rd_mux = lead_q;
      vcs_pkg::ADDR_HOLD_TRAIL: rd_mux = trail_q;
      vcs_pkg::ADDR_SYNC_STAT:  rd_mux = stat;
      vcs_pkg::ADDR_OUT_FORMAT: rd_mux = fmt_q;
      vcs_pkg::ADDR_FACTORY_A:  rd_mux = fact_a_q;
      vcs_pkg::ADDR_FACTORY_B:  rd_mux = fact_b_q;
      default:                  rd_mux = 8'h00;
    endcase
  endfunction

  always_comb rd_byte = rd_mux(ptr_q, sif.status);

  // ----------------------------------------
  // serial line sampling
  // ----------------------------------------
  // pins are synchronous already; the extra stage only gives edges
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      scl_qq <= 1'b1;
      sda_q <= 1'b1;
      sda_qq <= 1'b1;
    end else begin
      scl_q <= scl_i;
      scl_qq <= scl_q;
      sda_q <= sda_i;
      sda_qq <= sda_q;
    end
  end
  assign scl_rise = scl_q & ~scl_qq;
  assign scl_fall = ~scl_q & scl_qq;
  assign start_det = scl_q & scl_qq & ~sda_q & sda_qq;
  assign stop_det = scl_q & scl_qq & sda_q & ~sda_qq;

  // ----------------------------------------
  // serial state machine
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= vcs_pkg::ST_IDLE;
      bit_q <= '0;
      rx_q <= '0;
      tx_q <= '0;
      ptr_q <= '0;
      rw_q <= 1'b0;
      nack_q <= 1'b0;
      oe_q <= 1'b0;
      wr_stb_q <= 1'b0;
    end else begin
      wr_stb_q <= 1'b0;
      if (start_det) begin
        st_q <= vcs_pkg::ST_ADDR;
        bit_q <= '0;
        oe_q <= 1'b0;
      end else if (stop_det) begin
        st_q <= vcs_pkg::ST_IDLE;
        oe_q <= 1'b0;
      end else begin
        if (scl_rise && (bit_q != 4'h8)) begin
          rx_q <= {rx_q[6:0], sda_q};
          bit_q <= bit_q + 1'b1;
        end
        case (st_q)
          vcs_pkg::ST_IDLE: begin
            oe_q <= 1'b0;
          end
          vcs_pkg::ST_ADDR: begin
            if (scl_fall && bit_q == 4'h8) begin
              if (rx_q[7:1] == DEV_ADDR) begin
                rw_q <= rx_q[0];
                oe_q <= 1'b1;
                st_q <= vcs_pkg::ST_AACK;
              end else begin
                st_q <= vcs_pkg::ST_IDLE;
              end
            end
          end
          vcs_pkg::ST_AACK: begin
            if (scl_fall) begin
              bit_q <= '0;
              if (rw_q) begin
                // RQ24 status snapshot at byte load
                tx_q <= rd_byte;
                oe_q <= ~rd_byte[7];
                st_q <= vcs_pkg::ST_RDATA;
              end else begin
                oe_q <= 1'b0;
                st_q <= vcs_pkg::ST_PTR;
              end
            end
          end
          vcs_pkg::ST_PTR: begin
            if (scl_fall && bit_q == 4'h8) begin
              ptr_q <= rx_q;
              oe_q <= 1'b1;
              st_q <= vcs_pkg::ST_PACK;
            end
          end
          vcs_pkg::ST_PACK, vcs_pkg::ST_WACK: begin
            if (scl_fall) begin
              oe_q <= 1'b0;
              bit_q <= '0;
              if (st_q == vcs_pkg::ST_WACK) ptr_q <= ptr_q + 1'b1;
              st_q <= vcs_pkg::ST_WDATA;
            end
          end
          vcs_pkg::ST_WDATA: begin
            if (scl_fall && bit_q == 4'h8) begin
              wr_stb_q <= 1'b1;
              oe_q <= 1'b1;
              st_q <= vcs_pkg::ST_WACK;
            end
          end
          vcs_pkg::ST_RDATA: begin
            if (scl_fall) begin
              // bit count comes from the rising-edge shifter only
              if (bit_q == 4'h8) begin
                oe_q <= 1'b0;
                ptr_q <= ptr_q + 1'b1;
                st_q <= vcs_pkg::ST_RACK;
              end else begin
                tx_q <= {tx_q[6:0], 1'b0};
                oe_q <= ~tx_q[6];
              end
            end
          end
          vcs_pkg::ST_RACK: begin
            if (scl_rise) nack_q <= sda_q;
            if (scl_fall) begin
              if (nack_q) begin
                st_q <= vcs_pkg::ST_IDLE;
              end else begin
                bit_q <= '0;
                tx_q <= rd_byte;
                oe_q <= ~rd_byte[7];
                st_q <= vcs_pkg::ST_RDATA;
              end
            end
          end
          default: begin
            st_q <= vcs_pkg::ST_IDLE;
            oe_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // open drain: the line is only ever pulled low
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) zero_q <= 1'b0;
    else zero_q <= 1'b0;
  end

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  // RQ23 read-only offsets fall to default
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pll_up_q <= vcs_pkg::RST_PLL_UPPER;
      pll_lo_q <= vcs_pkg::RST_PLL_LOWER;
      sep_limit_q <= vcs_pkg::RST_SEP_LIMIT;
      lead_q <= vcs_pkg::RST_HOLD_LEAD;
      trail_q <= vcs_pkg::RST_HOLD_TRAIL;
      fmt_q <= vcs_pkg::RST_OUT_FORMAT;
      fact_a_q <= vcs_pkg::RST_FACTORY_A;
      fact_b_q <= vcs_pkg::RST_FACTORY_B;
    end else if (wr_stb_q) begin
      case (ptr_q)
        vcs_pkg::ADDR_PLL_UPPER:  pll_up_q <= rx_q;
        vcs_pkg::ADDR_PLL_LOWER:  pll_lo_q <= rx_q;
        vcs_pkg::ADDR_SEP_LIMIT:  sep_limit_q <= rx_q;
        vcs_pkg::ADDR_HOLD_LEAD:  lead_q <= rx_q;
        vcs_pkg::ADDR_HOLD_TRAIL: trail_q <= rx_q;
        vcs_pkg::ADDR_OUT_FORMAT: fmt_q <= rx_q;
        vcs_pkg::ADDR_FACTORY_A:  fact_a_q <= rx_q;
        vcs_pkg::ADDR_FACTORY_B:  fact_b_q <= rx_q;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // pll divider transfer
  // ----------------------------------------
  // RQ21 RQ22 update only on lower write
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pll_val_q <= RST_VALUE;
      ratio_q <= RST_RATIO;
      load_q <= 1'b0;
    end else begin
      load_q <= 1'b0;
      if (wr_stb_q && ptr_q == vcs_pkg::ADDR_PLL_LOWER) begin
        // RQ19 RQ20 ratio value plus one, floored
        pll_val_q <= {pll_up_q, rx_q[vcs_pkg::PLL_LO_HI:vcs_pkg::PLL_LO_LO]};
        ratio_q <= div_ratio({pll_up_q, rx_q[vcs_pkg::PLL_LO_HI:vcs_pkg::PLL_LO_LO]});
        load_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // sync processor and outputs
  // ----------------------------------------
  assign sif.sep_limit = sep_limit_q;
  assign sif.lead_lines = lead_q;
  assign sif.trail_lines = trail_q;

  vcs_sync #(
    .DETECT_CYCLES (DETECT_CYCLES)
  ) u_sync (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .hsync_pin (hsync_pin),
    .sog_pin   (sog_pin),
    .vsync_pin (vsync_pin),
    .coast_pin (coast_pin),
    .sif       (sif.sync)
  );

  assign sda_o = zero_q;
  assign sda_oe = oe_q;
  // RQ9 RQ10 RQ11 RQ12 format bits
  assign dual_channel = fmt_q[vcs_pkg::OUT_DUAL];
  assign parallel_mode = fmt_q[vcs_pkg::OUT_PARALLEL];
  assign port_b_first = fmt_q[vcs_pkg::OUT_B_FIRST];
  assign fmt_422 = fmt_q[vcs_pkg::OUT_422];
  // RQ13 RQ14 RQ15 mux, bandwidth, clock
  assign input_mux_sel = fmt_q[vcs_pkg::OUT_MUX];
  assign bandwidth_sel = fmt_q[vcs_pkg::OUT_BW_HI:vcs_pkg::OUT_BW_LO];
  assign pll_bypass = fmt_q[vcs_pkg::OUT_EXT_CLK];
  assign pll_divide_value = pll_val_q;
  assign pll_divide_ratio = ratio_q;
  assign pll_load = load_q;
  assign pll_hold = sif.pll_hold;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_upper_no_load: assert property ( // RQ22
    wr_stb_q && ptr_q == vcs_pkg::ADDR_PLL_UPPER |=> $stable(pll_val_q) && !load_q)
    else $error("upper write changed divider");
  a_lower_loads: assert property ( // RQ19
    wr_stb_q && ptr_q == vcs_pkg::ADDR_PLL_LOWER
    |=> load_q && pll_val_q == {pll_up_q, rx_q[7:4]})
    else $error("lower write did not load divider");
  a_ratio_plus_one: assert property ( // RQ19
    load_q && pll_val_q != 12'h000 |-> ratio_q == {1'b0, pll_val_q} + 13'h0001)
    else $error("ratio not value plus one");
  a_ratio_floor: assert property ( // RQ20
    ratio_q >= 13'h0002) else $error("ratio below two");
  a_ro_write_ignored: assert property ( // RQ23
    wr_stb_q && (ptr_q == vcs_pkg::ADDR_SYNC_STAT || ptr_q == vcs_pkg::ADDR_READBACK_A)
    |=> $stable(fmt_q) && $stable(pll_up_q) && $stable(sep_limit_q) && $stable(fact_a_q))
    else $error("read-only write altered state");
  a_revision_read: assert property ( // RQ18
    scl_fall && st_q == vcs_pkg::ST_AACK && rw_q && ptr_q == vcs_pkg::ADDR_REVISION
    |=> tx_q == REVISION) else $error("revision read wrong");
  a_status_read: assert property ( // RQ24
    scl_fall && st_q == vcs_pkg::ST_AACK && rw_q && ptr_q == vcs_pkg::ADDR_SYNC_STAT
    |=> tx_q == $past(sif.status)) else $error("status read not captured");
  a_ext_clk_write: assert property ( // RQ15
    wr_stb_q && ptr_q == vcs_pkg::ADDR_OUT_FORMAT
    |=> pll_bypass == rx_q[0] && bandwidth_sel == rx_q[2:1])
    else $error("format write not applied");
endmodule
`default_nettype wire

/* include/vcs_pkg.sv */
// constants, field layout and types of the capture sync/output register slice
// assumes a single 25 MHz core clock and a byte-wide register space
package vcs_pkg;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_REVISION   = 8'h00;
  localparam logic [7:0] ADDR_PLL_UPPER  = 8'h01;
  localparam logic [7:0] ADDR_PLL_LOWER  = 8'h02;
  localparam logic [7:0] ADDR_SEP_LIMIT  = 8'h11;
  localparam logic [7:0] ADDR_HOLD_LEAD  = 8'h12;
  localparam logic [7:0] ADDR_HOLD_TRAIL = 8'h13;
  localparam logic [7:0] ADDR_SYNC_STAT  = 8'h14;
  localparam logic [7:0] ADDR_OUT_FORMAT = 8'h15;
  localparam logic [7:0] ADDR_FACTORY_A  = 8'h16;
  localparam logic [7:0] ADDR_FACTORY_B  = 8'h17;
  localparam logic [7:0] ADDR_READBACK_A = 8'h18;
  localparam logic [7:0] ADDR_READBACK_B = 8'h19;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] RST_PLL_UPPER  = 8'h69;
  localparam logic [7:0] RST_PLL_LOWER  = 8'hD0;
  localparam logic [7:0] RST_SEP_LIMIT  = 8'h20;
  localparam logic [7:0] RST_HOLD_LEAD  = 8'h00;
  localparam logic [7:0] RST_HOLD_TRAIL = 8'h00;
  localparam logic [7:0] RST_OUT_FORMAT = 8'hC6;
  localparam logic [7:0] RST_FACTORY_A  = 8'hFF;
  localparam logic [7:0] RST_FACTORY_B  = 8'h00;
  localparam logic [11:0] PLL_VALUE_MIN = 12'h001;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int OUT_DUAL = 7;
  localparam int OUT_PARALLEL = 6;
  localparam int OUT_B_FIRST = 5;
  localparam int OUT_422 = 4;
  localparam int OUT_MUX = 3;
  localparam int OUT_BW_HI = 2;
  localparam int OUT_BW_LO = 1;
  localparam int OUT_EXT_CLK = 0;
  localparam int PLL_LO_HI = 7;
  localparam int PLL_LO_LO = 4;
  // detector slots, also the status layout helpers
  localparam int SIG_HS = 0;
  localparam int SIG_SOG = 1;
  localparam int SIG_VS = 2;
  localparam int SIG_COAST = 3;
  localparam int SIG_SEP = 4;
  localparam int SIG_NUM = 5;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CORE_CLK_HZ = 25_000_000;
  localparam int SEP_CLK_HZ = 5_000_000;
  localparam int SEP_DIV = CORE_CLK_HZ / SEP_CLK_HZ;
  localparam int SEP_DIV_W = $clog2(SEP_DIV);
  localparam int DETECT_WINDOW_US = 100;
  localparam int DETECT_CYCLES = (CORE_CLK_HZ / 1_000_000) * DETECT_WINDOW_US;
  localparam int WIN_W = 16;
  localparam int LINE_W = 12;

  // ----------------------------------------
  // serial port states
  // ----------------------------------------
  typedef enum logic [8:0] {
    ST_IDLE  = 9'h001,
    ST_ADDR  = 9'h002,
    ST_AACK  = 9'h004,
    ST_PTR   = 9'h008,
    ST_PACK  = 9'h010,
    ST_WDATA = 9'h020,
    ST_WACK  = 9'h040,
    ST_RDATA = 9'h080,
    ST_RACK  = 9'h100
  } vcs_ser_state_e;

endpackage

/* include/vcs_sync_if.sv */
// carrier between the register slice and the sync processor
// assumes both ends run on core_clk
`timescale 1ns/1ns
`default_nettype none
interface vcs_sync_if;
  logic [7:0] sep_limit;
  logic [7:0] lead_lines;
  logic [7:0] trail_lines;
  logic [7:0] status;
  logic       pll_hold;
  modport regs (output sep_limit, output lead_lines, output trail_lines,
                input status, input pll_hold);
  modport sync (input sep_limit, input lead_lines, input trail_lines,
                output status, output pll_hold);
endinterface
`default_nettype wire

/* core/vcs_sync.sv */
// sync separator, presence/polarity detectors and pll hold window
// assumes sync pins already synchronous to core_clk
`timescale 1ns/1ns
`default_nettype none
module vcs_sync #(
  parameter int unsigned DETECT_CYCLES = vcs_pkg::DETECT_CYCLES
) (
  input  wire logic  core_clk,
  input  wire logic  rst_n,
  input  wire logic  hsync_pin,
  input  wire logic  sog_pin,
  input  wire logic  vsync_pin,
  input  wire logic  coast_pin,
  vcs_sync_if.sync   sif
);
  localparam int NS = vcs_pkg::SIG_NUM;
  localparam int WW = vcs_pkg::WIN_W;
  localparam int LW = vcs_pkg::LINE_W;
  localparam int DW = vcs_pkg::SEP_DIV_W;
  localparam logic [DW-1:0] DIV_LAST = DW'(vcs_pkg::SEP_DIV - 1);
  logic [vcs_pkg::SEP_DIV_W-1:0] div_q;
  logic tick_q, sep_q, line_act_q, frame_act_q, hold_q;
  logic [7:0] sep_cnt_q, trail_q;
  logic [WW-1:0] win_q;
  logic [WW-1:0] hi_q [NS];
  logic [NS-1:0] raw, raw_q, seen_q, pres_q, pol_q;
  logic [LW-1:0] lines_q, prev_q;
  logic [7:0] stat_q;
  logic line_act, frame_act, line_rise, frame_rise, lead_on, win_end;

  // ----------------------------------------
  // 5 MHz enable and detectors
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (div_q == DIV_LAST);
      div_q <= (div_q == DIV_LAST) ? '0 : div_q + 1'b1;
    end
  end
  assign raw = {sep_q, coast_pin, vsync_pin, sog_pin, hsync_pin};
  assign win_end = (win_q == WW'(DETECT_CYCLES - 1));
  // active high when the high phase is the short one
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      win_q <= '0;
      raw_q <= '0;
      seen_q <= '0;
      pres_q <= '0;
      pol_q <= '0;
      for (int i = 0; i < NS; i++) hi_q[i] <= '0;
    end else begin
      raw_q <= raw;
      win_q <= win_end ? '0 : win_q + 1'b1;
      for (int i = 0; i < NS; i++) begin
        if (win_end) begin
          pres_q[i] <= seen_q[i] | (raw[i] ^ raw_q[i]);
          pol_q[i] <= (hi_q[i] < WW'(DETECT_CYCLES / 2));
          seen_q[i] <= 1'b0;
          hi_q[i] <= '0;
        end else begin
          seen_q[i] <= seen_q[i] | (raw[i] ^ raw_q[i]);
          hi_q[i] <= hi_q[i] + WW'(raw[i]);
        end
      end
    end
  end

  // ----------------------------------------
  // separator and hold window
  // ----------------------------------------
  assign line_act = (pres_q[vcs_pkg::SIG_HS] ? hsync_pin : sog_pin)
    ~^ (pres_q[vcs_pkg::SIG_HS] ? pol_q[vcs_pkg::SIG_HS] : pol_q[vcs_pkg::SIG_SOG]);
  assign frame_act = pres_q[vcs_pkg::SIG_VS]
    ? (vsync_pin ~^ pol_q[vcs_pkg::SIG_VS]) : sep_q;
  assign line_rise = line_act & ~line_act_q;
  assign frame_rise = frame_act & ~frame_act_q;
  // no lead window until a frame sync has stored a nonzero line count
  assign lead_on = (sif.lead_lines != 8'h00) && (prev_q != '0)
    && (lines_q + LW'(sif.lead_lines) >= prev_q);
  // RQ2 threshold count at 5 MHz
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sep_q <= 1'b0;
      sep_cnt_q <= '0;
    end else if (tick_q) begin
      if (line_act == sep_q) begin
        sep_cnt_q <= '0;
      end else if (sep_cnt_q == sif.sep_limit) begin
        sep_q <= line_act;
        sep_cnt_q <= '0;
      end else begin
        sep_cnt_q <= sep_cnt_q + 1'b1;
      end
    end
  end
  // RQ4 RQ5 lead and trail lines
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      line_act_q <= 1'b0;
      frame_act_q <= 1'b0;
      lines_q <= '0;
      prev_q <= '0;
      trail_q <= '0;
      hold_q <= 1'b0;
    end else begin
      line_act_q <= line_act;
      frame_act_q <= frame_act;
      hold_q <= lead_on | (trail_q != 8'h00);
      if (frame_rise) begin
        prev_q <= lines_q;
        lines_q <= '0;
        trail_q <= sif.trail_lines;
      end else if (line_rise) begin
        lines_q <= lines_q + 1'b1;
        if (trail_q != 8'h00) trail_q <= trail_q - 1'b1;
      end
    end
  end
  // RQ6 RQ7 RQ8 status byte
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) stat_q <= '0;
    else stat_q <= {pres_q[vcs_pkg::SIG_HS] | pres_q[vcs_pkg::SIG_SOG],
                    ~pres_q[vcs_pkg::SIG_HS] & pres_q[vcs_pkg::SIG_SOG],
                    pres_q[vcs_pkg::SIG_HS] ? pol_q[vcs_pkg::SIG_HS] : pol_q[vcs_pkg::SIG_SOG],
                    pres_q[vcs_pkg::SIG_VS] | pres_q[vcs_pkg::SIG_SEP],
                    ~pres_q[vcs_pkg::SIG_VS],
                    ~(pres_q[vcs_pkg::SIG_VS] ? pol_q[vcs_pkg::SIG_VS] : pol_q[vcs_pkg::SIG_SEP]),
                    pres_q[vcs_pkg::SIG_SOG], pol_q[vcs_pkg::SIG_COAST]};
  end
  assign sif.status = stat_q;
  assign sif.pll_hold = hold_q;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // RQ2 toggle only at limit
  a_sep_toggle_limit: assert property ($changed(sep_q) |-> $past(tick_q)
    && $past(sep_cnt_q) == $past(sif.sep_limit)) else $error("separator toggled early");
  // RQ5 trail holds
  a_trail_hold: assert property (frame_rise && sif.trail_lines != 8'h00 |-> ##2 hold_q)
    else $error("trail hold missing");
  // RQ6 line source bit
  a_line_src_bit: assert property (##1 stat_q[6] == $past(~pres_q[vcs_pkg::SIG_HS]
    & pres_q[vcs_pkg::SIG_SOG])) else $error("line source bit wrong");
endmodule
`default_nettype wire

/* sim/vcs_host.sv */
// host master model for the two-wire register port
// assumes sda is pulled up outside; each bus phase lasts 4 core_clk cycles
`timescale 1ns/1ns
`default_nettype none
module vcs_host #(
  parameter logic [6:0] DEV_ADDR = 7'h4C
) (
  input  wire logic core_clk,
  input  wire logic sda_in,
  output logic      scl = 1'b1,
  output logic      sda_pull = 1'b0
);
  // ----------------------------------------
  // bus phases
  // ----------------------------------------
  task automatic st(input logic c, input logic d);
    scl = c;
    sda_pull = ~d;
    repeat (4) @(negedge core_clk);
  endtask
  // scl falls before sda moves, so no false start or stop
  task automatic low();
    st(1'b0, ~sda_pull);
  endtask
  task automatic start();
    low();
    st(1'b0, 1'b1);
    st(1'b1, 1'b1);
    st(1'b1, 1'b0);
  endtask
  task automatic stop();
    low();
    st(1'b0, 1'b0);
    st(1'b1, 1'b0);
    st(1'b1, 1'b1);
  endtask
  task automatic xfer(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      low();
      st(1'b0, d[i]);
      st(1'b1, d[i]);
      q[i] = sda_in;
    end
  endtask
  task automatic probe(input logic [6:0] dev, output logic ack);
    logic [8:0] q;
    start();
    xfer({dev, 2'b01}, q);
    stop();
    ack = ~q[0];
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v, output logic ack);
    logic [8:0] q0, q1, q2;
    start();
    xfer({DEV_ADDR, 2'b01}, q0);
    xfer({a, 1'b1}, q1);
    xfer({v, 1'b1}, q2);
    stop();
    ack = ~(q0[0] | q1[0] | q2[0]);
  endtask
  // pointer write, repeated start, one byte ended by a nack
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    logic [8:0] q;
    start();
    xfer({DEV_ADDR, 2'b01}, q);
    xfer({a, 1'b1}, q);
    start();
    xfer({DEV_ADDR, 2'b11}, q);
    xfer(9'h1FF, q);
    stop();
    v = q[8:1];
  endtask
endmodule
`default_nettype wire

/* sim/video_capture_sync_output_regs_test.sv */
// self-checking bench of the capture sync/output register slice
// assumes vcs_host as bus master; sog and coast held low, vsync pulsed six times
`timescale 1ns/1ns
`default_nettype none
module video_capture_sync_output_regs_test;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] exp_rd;
  } vcs_row_s;
  logic            core_clk = 1'b0;
  logic            rst_n = 1'b0;
  logic            hsync_pin = 1'b0;
  logic            vsync_pin = 1'b0;
  logic            pll_hold;
  logic            hold_seen = 1'b0;
  logic            scl;
  logic            host_pull;
  logic            sda_o;
  logic            sda_oe;
  logic            pll_load;
  logic            load_seen = 1'b0;
  logic            ack;
  logic [7:0]      rdata;
  logic [11:0]     pll_value;
  logic [12:0]     pll_ratio;
  wire logic [7:0] fmt;
  wire logic       sda = ~(host_pull | (sda_oe & ~sda_o));
  int              miscompares = 0;
  int              cmp_count = 0;
  int              cycles = 0;
  // 0x0F stands for the power/clamp bit, unmapped here; 0x17 is never written
  vcs_row_s rows [8] = '{'{8'h11, 8'h40, 8'h40}, '{8'h12, 8'h03, 8'h03},
    '{8'h13, 8'h02, 8'h02}, '{8'h16, 8'hFE, 8'hFE}, '{8'h15, 8'h39, 8'h39},
    '{8'h00, 8'hAA, 8'h5A}, '{8'h18, 8'h55, 8'h00}, '{8'h0F, 8'h01, 8'h00}};
  logic [15:0] rst_tab [8] = '{16'h0169, 16'h02D0, 16'h1120, 16'h1200,
    16'h1300, 16'h15C6, 16'h16FF, 16'h1700};
  // ----------------------------------------
  // clock, pins, design
  // ----------------------------------------
  always #20 core_clk = ~core_clk;
  always @(negedge core_clk) if (cycles % 20 == 0) hsync_pin <= ~hsync_pin;
  always @(posedge core_clk) if (pll_load === 1'b1) load_seen <= 1'b1;
  always @(posedge core_clk) if (pll_hold === 1'b1) hold_seen <= 1'b1;
  vcs_host i_host (.core_clk(core_clk), .sda_in(sda), .scl(scl), .sda_pull(host_pull));
  vcs_regs #(.DETECT_CYCLES(64)) i_dut (.core_clk(core_clk), .rst_n(rst_n), .scl_i(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .hsync_pin(hsync_pin), .sog_pin(1'b0),
    .vsync_pin(vsync_pin), .coast_pin(1'b0), .dual_channel(fmt[7]), .parallel_mode(fmt[6]),
    .port_b_first(fmt[5]), .fmt_422(fmt[4]), .input_mux_sel(fmt[3]),
    .bandwidth_sel(fmt[2:1]), .pll_bypass(fmt[0]), .pll_divide_value(pll_value),
    .pll_divide_ratio(pll_ratio), .pll_load(pll_load), .pll_hold(pll_hold));
  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // whole run needs about 15000 cycles
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (12) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (2) @(negedge core_clk);
    foreach (rows[i]) begin
      i_host.wr(rows[i].addr, rows[i].wdata, ack);
      i_host.rd(rows[i].addr, rdata);
      chk(16'(ack), 16'h0001);
      chk(16'(rdata), 16'(rows[i].exp_rd));
    end
    $display("register rows done");
    for (int b = 0; b < 4; b++) begin
      i_host.wr(8'h15, 8'hC6 ^ {4{b[1:0]}}, ack);
      chk(16'(fmt), 16'(8'hC6 ^ {4{b[1:0]}}));
    end
    i_host.wr(8'h01, 8'hFF, ack);
    chk(16'(pll_value), 16'h069D);
    chk(16'(load_seen), 16'h0000);
    i_host.wr(8'h02, 8'hF0, ack);
    chk(16'(pll_value), 16'h0FFF);
    chk(16'(pll_ratio), 16'h1000);
    chk(16'(load_seen), 16'h0001);
    i_host.wr(8'h01, 8'h00, ack);
    i_host.wr(8'h02, 8'h10, ack);
    chk(16'(pll_ratio), 16'h0002);
    i_host.rd(8'h14, rdata);
    chk(16'(rdata & 8'h90), 16'h0080);
    chk(16'(hold_seen), 16'h0000);
    repeat (6) begin
      vsync_pin = 1'b1;
      repeat (4) @(negedge core_clk);
      vsync_pin = 1'b0;
      repeat (44) @(negedge core_clk);
    end
    chk(16'(hold_seen), 16'h0001);
    i_host.probe(7'h4D, ack);
    chk(16'(ack), 16'h0000);
    $display("awkward cases done");
    rst_n = 1'b0;
    repeat (3) @(negedge core_clk);
    chk(16'(fmt), 16'h00C6);
    chk(16'(pll_value), 16'h069D);
    chk(16'(pll_ratio), 16'h069E);
    rst_n = 1'b1;
    repeat (2) @(negedge core_clk);
    foreach (rst_tab[i]) begin
      i_host.rd(rst_tab[i][15:8], rdata);
      chk(16'(rdata), 16'(rst_tab[i][7:0]));
    end
    $display("reset values done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
